// file: dec_exec_pkg.sv
// shared constants, types and helpers for the decrement execution block
package dec_exec_pkg;
  localparam int PTR_W    = 24;
  localparam int WORD_W   = 16;
  localparam int ACC_W    = 36;
  localparam int ACC_HI_W = 20;
  localparam int NUM_PTR  = 8;
  localparam int SEL_W    = 3;
  localparam int FLAG_W   = 8;

  // condition flag bit positions
  localparam int FLG_C  = 0;
  localparam int FLG_V  = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_N  = 3;
  localparam int FLG_U  = 4;
  localparam int FLG_E  = 5;
  localparam int FLG_L  = 6;
  localparam int FLG_SZ = 7;

  localparam logic [PTR_W-1:0]    PTR_RST      = 24'h000000;
  localparam logic [FLAG_W-1:0]   FLAGS_RST    = 8'h00;
  localparam logic [ACC_W-1:0]    RESULT_RST   = 36'h0_0000_0000;
  localparam logic [PTR_W-1:0]    PTR_STEP_ONE = 24'h000001;
  localparam logic [PTR_W-1:0]    PTR_STEP_TWO = 24'h000002;
  localparam logic [WORD_W-1:0]   WORD_MIN     = 16'h8000;
  localparam logic [ACC_HI_W-1:0] ACC_HI_MIN   = 20'h80000;

  // cycle counts of the word decrement forms
  localparam logic [2:0] CYC_REG      = 3'h1;
  localparam logic [2:0] CYC_RN       = 3'h3;
  localparam logic [2:0] CYC_RN_DISP  = 3'h4;
  localparam logic [2:0] CYC_SP       = 3'h4;
  localparam logic [2:0] CYC_ABS16    = 3'h3;
  localparam logic [2:0] CYC_ABS24    = 3'h4;

  typedef enum logic [1:0] {OP_PTR_ONE, OP_PTR_TWO, OP_WORD} op_t;
  typedef enum logic [2:0] {FORM_REG, FORM_RN, FORM_RN_DISP, FORM_SP, FORM_ABS16, FORM_ABS24} form_t;

  function automatic logic [2:0] form_cycles(input form_t f);
    logic [2:0] c;
    c = CYC_REG;
    unique case (f)
      FORM_REG:     c = CYC_REG;
      FORM_RN:      c = CYC_RN;
      FORM_RN_DISP: c = CYC_RN_DISP;
      FORM_SP:      c = CYC_SP;
      FORM_ABS16:   c = CYC_ABS16;
      FORM_ABS24:   c = CYC_ABS24;
      default:      c = CYC_REG;
    endcase
    return c;
  endfunction
endpackage

// file: dec_alu_if.sv
// operand and result bundle between the sequencer and the decrement arithmetic
interface dec_alu_if;
  import dec_exec_pkg::*;
  logic [WORD_W-1:0] word_val;
  logic [ACC_W-1:0]  acc_val;
  logic              dest_acc;
  logic [FLAG_W-1:0] flags_old;
  logic [ACC_W-1:0]  word_res;
  logic [FLAG_W-1:0] flags_new;
  logic [PTR_W-1:0]  ptr_val;
  logic              two_step;
  logic [PTR_W-1:0]  ptr_res;

  modport alu (input word_val, acc_val, dest_acc, flags_old, ptr_val, two_step,
               output word_res, flags_new, ptr_res);
  modport ctl (output word_val, acc_val, dest_acc, flags_old, ptr_val, two_step,
               input word_res, flags_new, ptr_res);
endinterface

// file: dec_alu.sv
// combinational decrement arithmetic and condition flag generation
module dec_alu
  import dec_exec_pkg::*;
(
  dec_alu_if.alu bus
);
  logic [WORD_W-1:0]   res16;
  logic [ACC_HI_W-1:0] hi;
  logic [ACC_HI_W-1:0] res20;
  logic                c;
  logic                v;

  always_comb begin
    bus.ptr_res = bus.ptr_val - (bus.two_step ? PTR_STEP_TWO : PTR_STEP_ONE);
  end

  always_comb begin
    res16 = bus.word_val - WORD_W'(1);
    hi    = bus.acc_val[ACC_W-1 -: ACC_HI_W];
    res20 = hi - ACC_HI_W'(1);
    bus.flags_new          = bus.flags_old;
    if (bus.dest_acc) begin
      // upper 20 bits only, lower part kept
      bus.word_res = {res20, bus.acc_val[WORD_W-1:0]};
      c = (hi == '0);
      v = (hi == ACC_HI_MIN);
      bus.flags_new[FLG_N] = res20[ACC_HI_W-1];
      bus.flags_new[FLG_Z] = (res20 == '0);
      bus.flags_new[FLG_E] = !((&res20[ACC_HI_W-1:WORD_W-1]) || !(|res20[ACC_HI_W-1:WORD_W-1]));
      bus.flags_new[FLG_U] = !(res20[WORD_W-1] ^ res20[WORD_W-2]);
    end else begin
      bus.word_res = {{(ACC_W-WORD_W){1'b0}}, res16};
      c = (bus.word_val == '0);
      v = (bus.word_val == WORD_MIN);
      bus.flags_new[FLG_N] = res16[WORD_W-1];
      bus.flags_new[FLG_Z] = (res16 == '0);
      bus.flags_new[FLG_E] = 1'b0;
      bus.flags_new[FLG_U] = !(res16[WORD_W-1] ^ res16[WORD_W-2]);
    end
    bus.flags_new[FLG_C] = c;
    bus.flags_new[FLG_V] = v;
    bus.flags_new[FLG_L] = bus.flags_old[FLG_L] | v;
  end
endmodule

// file: decrement_instruction_exec.sv
// execution sequencer for the pointer and word decrement instructions
// Notes on behaviour
// - the single-step pointer decrement subtracts one from the chosen pointer and writes it back there.
// - the long-step pointer decrement subtracts two from the chosen pointer and writes it back there.
// - both pointer decrements work on the full 24-bit pointer with borrow through every bit.
// - neither pointer decrement changes any condition flag.
// - the single-step pointer decrement is one program word and finishes in one cycle.
// - the long-step pointer decrement finishes in exactly one cycle.
// - the word decrement takes one to four cycles depending on its operand form.
// - the word decrement subtracts one from 16 bits, or from the upper 20 bits of an accumulator keeping its low part.
// - carry is set on a borrow out of bit 15, or out of bit 35 for an accumulator.
// - word decrement flags follow 20-bit rules for accumulators and 16-bit rules otherwise.
module decrement_instruction_exec
  import dec_exec_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              issue_in,
  input  wire op_t               op_in,
  input  wire form_t             form_in,
  input  wire logic [SEL_W-1:0]  ptr_sel_in,
  input  wire logic              dest_acc_in,
  input  wire logic [WORD_W-1:0] word_value_in,
  input  wire logic [ACC_W-1:0]  acc_value_in,
  input  wire logic [PTR_W-1:0]  mem_addr_in,
  input  wire logic [WORD_W-1:0] mem_rdata_in,
  input  wire logic              ptr_load_in,
  input  wire logic [SEL_W-1:0]  ptr_load_sel_in,
  input  wire logic [PTR_W-1:0]  ptr_load_data_in,
  input  wire logic              flags_load_in,
  input  wire logic [FLAG_W-1:0] flags_load_data_in,
  input  wire logic [SEL_W-1:0]  ptr_rd_sel_in,
  output logic                   ready_out,
  output logic                   done_out,
  output logic [ACC_W-1:0]       result_out,
  output logic                   mem_rd_out,
  output logic                   mem_wr_out,
  output logic [PTR_W-1:0]       mem_addr_out,
  output logic [WORD_W-1:0]      mem_wdata_out,
  output logic [FLAG_W-1:0]      flags_out,
  output logic [PTR_W-1:0]       ptr_rd_data_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_READ, ST_WRITE} state_t;

  state_t            state_r;
  logic [PTR_W-1:0]  ptr_r [NUM_PTR];
  logic [FLAG_W-1:0] flags_r;
  logic [ACC_W-1:0]  result_r;
  logic [PTR_W-1:0]  addr_r;
  logic [WORD_W-1:0] wdata_r;
  logic              done_r;
  logic [PTR_W-1:0]  ptr_rd_r;
  logic              accept;
  logic              ptr_op;
  logic              word_reg;
  logic              word_mem;

  dec_alu_if alu_bus ();

  dec_alu u_alu (
    .bus (alu_bus.alu)
  );

  assign ready_out = (state_r == ST_IDLE);
  assign accept    = issue_in && ready_out;
  assign ptr_op    = accept && (op_in != OP_WORD);
  assign word_reg  = accept && (op_in == OP_WORD) && (form_in == FORM_REG);
  assign word_mem  = accept && (op_in == OP_WORD) && (form_in != FORM_REG);

  // memory operand in the read cycle, register operand otherwise
  assign alu_bus.word_val  = (state_r == ST_READ) ? mem_rdata_in : word_value_in;
  assign alu_bus.acc_val   = acc_value_in;
  assign alu_bus.dest_acc  = (state_r == ST_READ) ? 1'b0 : dest_acc_in;
  assign alu_bus.flags_old = flags_r;
  assign alu_bus.ptr_val   = ptr_r[ptr_sel_in];
  assign alu_bus.two_step  = (op_in == OP_PTR_TWO);

  assign done_out      = done_r;
  assign result_out    = result_r;
  assign mem_rd_out    = (state_r == ST_READ);
  assign mem_wr_out    = (state_r == ST_WRITE);
  assign mem_addr_out  = addr_r;
  assign mem_wdata_out = wdata_r;
  assign flags_out     = flags_r;
  assign ptr_rd_data_out = ptr_rd_r;

  // sequencer for the memory word decrement forms
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (word_mem) begin
            state_r <= (form_cycles(form_in) == CYC_RN_DISP) ? ST_ADDR : ST_READ;
          end
        end
        ST_ADDR:  state_r <= ST_READ;
        ST_READ:  state_r <= ST_WRITE;
        ST_WRITE: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_r <= 1'b0;
    end else begin
      done_r <= ptr_op || word_reg || (state_r == ST_WRITE);
    end
  end

  // pointer file; an instruction wins over a same-cycle load
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr_r[i] <= PTR_RST;
      end
    end else begin
      if (ptr_load_in) begin
        ptr_r[ptr_load_sel_in] <= ptr_load_data_in;
      end
      if (ptr_op) begin
        ptr_r[ptr_sel_in] <= alu_bus.ptr_res;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_rd_r <= PTR_RST;
    end else begin
      ptr_rd_r <= ptr_r[ptr_rd_sel_in];
    end
  end

  // flags change on word decrements and on a flags load; a word decrement wins over a same-cycle load
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_r <= FLAGS_RST;
    end else if (word_reg || (state_r == ST_READ)) begin
      flags_r <= alu_bus.flags_new;
    end else if (flags_load_in) begin
      flags_r <= flags_load_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_r <= RESULT_RST;
    end else if (word_reg || (state_r == ST_READ)) begin
      result_r <= alu_bus.word_res;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_r  <= PTR_RST;
      wdata_r <= '0;
    end else begin
      if (word_mem) begin
        addr_r <= mem_addr_in;
      end
      if (state_r == ST_READ) begin
        wdata_r <= alu_bus.word_res[WORD_W-1:0];
      end
    end
  end

  // helper logic for the checks below
  logic [PTR_W-1:0] sel_ptr_val;
  logic [SEL_W-1:0] sel_q;
  assign sel_ptr_val = ptr_r[ptr_sel_in];
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_q <= '0;
    end else begin
      sel_q <= ptr_sel_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence mem_short_s;
    mem_rd_out ##1 (mem_wr_out && !mem_rd_out) ##1 (done_out && ready_out);
  endsequence

  sequence mem_long_s;
    (!mem_rd_out && !ready_out) ##1 mem_short_s;
  endsequence

  ptr_one_step_a: assert property (
    ptr_op && op_in == OP_PTR_ONE
    |=> ptr_r[sel_q] == $past(sel_ptr_val) - PTR_STEP_ONE)
    else $error("pointer single step wrong");

  ptr_two_step_a: assert property (
    ptr_op && op_in == OP_PTR_TWO |=> ptr_r[sel_q] == $past(sel_ptr_val) - PTR_STEP_TWO)
    else $error("pointer double step wrong");

  ptr_full_borrow_a: assert property (
    ptr_op && op_in == OP_PTR_ONE && sel_ptr_val == PTR_RST |=> &ptr_r[sel_q])
    else $error("pointer borrow not carried through 24 bits");

  flags_kept_a: assert property (
    ptr_op && !flags_load_in |=> $stable(flags_r))
    else $error("pointer decrement touched flags");

  ptr_one_cycle_a: assert property (
    ptr_op |=> done_out && ready_out && !mem_rd_out && !mem_wr_out)
    else $error("pointer decrement not single cycle");

  word_cycles_a: assert property (
    word_mem |=> if (form_cycles($past(form_in)) == CYC_RN_DISP) mem_long_s else mem_short_s)
    else $error("word decrement memory timing wrong");

  acc_low_kept_a: assert property (
    word_reg && dest_acc_in |=> result_out[WORD_W-1:0] == $past(acc_value_in[WORD_W-1:0]) && done_out)
    else $error("accumulator low part changed");

  word_borrow_a: assert property (
    word_reg && !dest_acc_in && word_value_in == '0 |=> flags_r[FLG_C] && flags_r[FLG_N] && !flags_r[FLG_Z])
    else $error("borrow from bit 15 not flagged");

  acc_zero_a: assert property (
    word_reg && dest_acc_in && acc_value_in[ACC_W-1 -: ACC_HI_W] == ACC_HI_W'(1)
    |=> flags_r[FLG_Z] && !flags_r[FLG_C] && !flags_r[FLG_E])
    else $error("20-bit flag rules not applied");

  mem_writeback_a: assert property (
    mem_rd_out |=> mem_wr_out && mem_wdata_out == $past(mem_rdata_in) - WORD_W'(1) && $stable(mem_addr_out))
    else $error("memory write-back wrong");
endmodule

// file: decrement_instruction_exec_tb.sv
// self-checking testbench for the decrement execution block
module decrement_instruction_exec_tb
  import dec_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_in;
  logic              rst_in;
  logic              issue_in;
  op_t               op_in;
  form_t             form_in;
  logic [SEL_W-1:0]  ptr_sel_in;
  logic              dest_acc_in;
  logic [WORD_W-1:0] word_value_in;
  logic [ACC_W-1:0]  acc_value_in;
  logic [PTR_W-1:0]  mem_addr_in;
  logic [WORD_W-1:0] mem_rdata_in;
  logic              ptr_load_in;
  logic [SEL_W-1:0]  ptr_load_sel_in;
  logic [PTR_W-1:0]  ptr_load_data_in;
  logic              flags_load_in;
  logic [FLAG_W-1:0] flags_load_data_in;
  logic [SEL_W-1:0]  ptr_rd_sel_in;
  logic              ready_out;
  logic              done_out;
  logic [ACC_W-1:0]  result_out;
  logic              mem_rd_out;
  logic              mem_wr_out;
  logic [PTR_W-1:0]  mem_addr_out;
  logic [WORD_W-1:0] mem_wdata_out;
  logic [FLAG_W-1:0] flags_out;
  logic [PTR_W-1:0]  ptr_rd_data_out;
  int                num_errors;
  int                n_checks;
  int                cyc;
  logic              rd_seen;

  decrement_instruction_exec i_dut (.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in), .op_in(op_in),
    .form_in(form_in), .ptr_sel_in(ptr_sel_in), .dest_acc_in(dest_acc_in), .word_value_in(word_value_in),
    .acc_value_in(acc_value_in), .mem_addr_in(mem_addr_in), .mem_rdata_in(mem_rdata_in),
    .ptr_load_in(ptr_load_in), .ptr_load_sel_in(ptr_load_sel_in), .ptr_load_data_in(ptr_load_data_in),
    .flags_load_in(flags_load_in), .flags_load_data_in(flags_load_data_in), .ptr_rd_sel_in(ptr_rd_sel_in),
    .ready_out(ready_out), .done_out(done_out), .result_out(result_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .flags_out(flags_out), .ptr_rd_data_out(ptr_rd_data_out));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check_val(string name, logic [ACC_W-1:0] exp, logic [ACC_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_cyc(string name, int exp, int got);
    n_checks++;
    if (got != exp) begin
      num_errors++;
      $display("FAIL %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // issue one instruction and count cycles until done; memory writes judged as they appear
  task automatic do_op(op_t op, form_t f, logic [SEL_W-1:0] sel, logic [PTR_W-1:0] ea, logic [WORD_W-1:0] rd);
    @(posedge clk_in);
    issue_in <= 1'b1;
    op_in <= op;
    form_in <= f;
    ptr_sel_in <= sel;
    ptr_rd_sel_in <= sel;
    mem_addr_in <= ea;
    mem_rdata_in <= rd;
    @(posedge clk_in);
    issue_in <= 1'b0;
    #1;
    cyc = 1;
    rd_seen = 1'b0;
    while (done_out !== 1'b1 && cyc < 10) begin
      check_val("busy_ready", 36'h0, {35'h0, ready_out});
      if (mem_rd_out === 1'b1) rd_seen = 1'b1;
      if (mem_wr_out === 1'b1) begin
        check_val("read_before_write", 36'h1, {35'h0, rd_seen});
        check_val("wr_addr", {12'h0, ea}, {12'h0, mem_addr_out});
        check_val("wr_data", {20'h0, rd - 16'h0001}, {20'h0, mem_wdata_out});
      end
      @(posedge clk_in);
      #1;
      cyc++;
    end
    check_val("done_ready", 36'h1, {35'h0, ready_out});
  endtask

  task automatic load_ptr(logic [SEL_W-1:0] sel, logic [PTR_W-1:0] val);
    @(posedge clk_in);
    ptr_load_in <= 1'b1;
    ptr_load_sel_in <= sel;
    ptr_load_data_in <= val;
    @(posedge clk_in);
    ptr_load_in <= 1'b0;
  endtask

  task automatic ptr_case(op_t op, logic [SEL_W-1:0] sel, logic [PTR_W-1:0] exp);
    do_op(op, FORM_REG, sel, 24'h0, 16'h0);
    check_cyc("ptr_cycles", 1, cyc);
    @(posedge clk_in);
    #1;
    check_val("ptr_value", {12'h0, exp}, {12'h0, ptr_rd_data_out});
    check_val("ptr_flags", 36'hA5, {28'h0, flags_out});
  endtask

  task automatic test_pointer();
    @(posedge clk_in);
    flags_load_in <= 1'b1;
    flags_load_data_in <= 8'hA5;
    @(posedge clk_in);
    flags_load_in <= 1'b0;
    load_ptr(3'h3, 24'h002222);
    ptr_case(OP_PTR_ONE, 3'h3, 24'h002221);
    ptr_case(OP_PTR_TWO, 3'h3, 24'h00221F);
    load_ptr(3'h5, 24'h000000);
    ptr_case(OP_PTR_ONE, 3'h5, 24'hFFFFFF);
    ptr_case(OP_PTR_TWO, 3'h5, 24'hFFFFFD);
    load_ptr(3'h7, 24'h010001);
    ptr_case(OP_PTR_TWO, 3'h7, 24'h00FFFF);
    $display("test_pointer done");
  endtask

  task automatic reg_case(logic acc, logic [WORD_W-1:0] w, logic [ACC_W-1:0] a, logic [ACC_W-1:0] exp,
                          logic c, logic z);
    @(posedge clk_in);
    dest_acc_in <= acc;
    word_value_in <= w;
    acc_value_in <= a;
    do_op(OP_WORD, FORM_REG, 3'h0, 24'h0, 16'h0);
    check_cyc("reg_cycles", 1, cyc);
    check_val("reg_result", exp, result_out);
    check_val("reg_carry", {35'h0, c}, {35'h0, flags_out[FLG_C]});
    check_val("reg_zero", {35'h0, z}, {35'h0, flags_out[FLG_Z]});
  endtask

  task automatic test_word_reg();
    reg_case(1'b0, 16'h0000, 36'h0, 36'h0_0000_FFFF, 1'b1, 1'b0);
    reg_case(1'b0, 16'h0001, 36'h0, 36'h0_0000_0000, 1'b0, 1'b1);
    reg_case(1'b1, 16'h0000, 36'h0_0001_0033, 36'h0_0000_0033, 1'b0, 1'b1);
    reg_case(1'b1, 16'h0000, 36'h0_0000_0033, 36'hF_FFFF_0033, 1'b1, 1'b0);
    $display("test_word_reg done");
  endtask

  task automatic test_word_mem();
    form_t forms [5];
    int    cycles [5];
    forms = '{FORM_RN, FORM_RN_DISP, FORM_SP, FORM_ABS16, FORM_ABS24};
    cycles = '{3, 4, 4, 3, 4};
    for (int i = 0; i < 5; i++) begin
      do_op(OP_WORD, forms[i], 3'h0, 24'h00A000 + 24'(i), 16'h1000 * 16'(i));
      check_cyc("mem_cycles", cycles[i], cyc);
      check_val("mem_result", {20'h0, 16'h1000 * 16'(i) - 16'h0001}, result_out);
    end
    $display("test_word_mem done");
  endtask

  initial begin
    num_errors = 0;
    n_checks = 0;
    rst_in = 1'b1;
    issue_in = 1'b0;
    op_in = OP_PTR_ONE;
    form_in = FORM_REG;
    ptr_sel_in = 3'h0;
    dest_acc_in = 1'b0;
    word_value_in = 16'h0;
    acc_value_in = 36'h0;
    mem_addr_in = 24'h0;
    mem_rdata_in = 16'h0;
    ptr_load_in = 1'b0;
    ptr_load_sel_in = 3'h0;
    ptr_load_data_in = 24'h0;
    flags_load_in = 1'b0;
    flags_load_data_in = 8'h00;
    ptr_rd_sel_in = 3'h0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    test_pointer();
    test_word_reg();
    test_word_mem();
    report_and_stop();
  end

  initial begin
    #20us;
    num_errors++;
    $display("FAIL watchdog expected completion seen timeout");
    report_and_stop();
  end
endmodule
